// >>> src/tws_cond.sv
// bus condition detector: clock edges, start and stop
// assumes scl and sda are already synchronised to clk
`timescale 1ns/100ps
`default_nettype none
module tws_cond (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // synced bus lines
    input  wire logic scl,
    input  wire logic sda,
    // one-cycle event pulses
    output logic      scl_rise,
    output logic      scl_fall,
    output logic      start_det,
    output logic      stop_det
);

    logic scl_p_q;
    logic sda_p_q;
    wire  rise_w  = !scl_p_q && scl;
    wire  fall_w  = scl_p_q && !scl;
    // sda moving while scl stays high marks a condition
    wire  start_w = scl_p_q && scl && sda_p_q && !sda;
    wire  stop_w  = scl_p_q && scl && !sda_p_q && sda;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_p_q   <= 1'b1;
            sda_p_q   <= 1'b1;
            scl_rise  <= 1'b0;
            scl_fall  <= 1'b0;
            start_det <= 1'b0;
            stop_det  <= 1'b0;
        end else begin
            scl_p_q   <= scl;
            sda_p_q   <= sda;
            scl_rise  <= rise_w;
            scl_fall  <= fall_w;
            start_det <= start_w;
            stop_det  <= stop_w;
        end
    end

endmodule
`default_nettype wire

// >>> src/tws_pkg.sv
// shared constants for the two-wire slave receiver block
// assumes a 200 MHz system clock and an 8-bit register port
package tws_pkg;

    // timing
    localparam int CLK_PERIOD_NS  = 5;
    localparam int START_HOLD_NS  = 4000;
    localparam int START_HOLD_CYC = (START_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // register port
    localparam int REG_AW = 3;
    localparam int REG_DW = 8;
    localparam logic [2:0] REG_CTRL     = 3'h0;
    localparam logic [2:0] REG_STATUS   = 3'h1;
    localparam logic [2:0] REG_DATA     = 3'h2;
    localparam logic [2:0] REG_OWN_ADDR = 3'h3;
    localparam logic [2:0] REG_IRQ_STAT = 3'h4;
    localparam logic [2:0] REG_IRQ_MASK = 3'h5;

    // control fields
    localparam int CTRL_STEP  = 7;
    localparam int CTRL_ACK   = 6;
    localparam int CTRL_STA   = 5;
    localparam int CTRL_STO   = 4;
    localparam int CTRL_EN    = 2;
    localparam int OWN_GCE    = 0;
    localparam int PRESC_W    = 2;

    // interrupt status bits
    localparam int IRQ_W      = 3;
    localparam int IRQ_STEP   = 0;
    localparam int IRQ_STOP   = 1;
    localparam int IRQ_START  = 2;

    // reset values
    localparam logic [7:0] OWN_ADDR_RST = 8'h00;
    localparam logic [7:0] DATA_RST     = 8'hFF;

    // bus constants
    localparam logic [6:0] GC_ADDR       = 7'h00;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // status codes, low three bits always zero
    localparam logic [7:0] ST_NONE          = 8'hF8;
    localparam logic [7:0] ST_START_SENT    = 8'h08;
    localparam logic [7:0] ST_OWN_ACK       = 8'h60;
    localparam logic [7:0] ST_ARB_OWN       = 8'h68;
    localparam logic [7:0] ST_GC_ACK        = 8'h70;
    localparam logic [7:0] ST_ARB_GC        = 8'h78;
    localparam logic [7:0] ST_OWN_DATA_ACK  = 8'h80;
    localparam logic [7:0] ST_OWN_DATA_NACK = 8'h88;
    localparam logic [7:0] ST_GC_DATA_ACK   = 8'h90;
    localparam logic [7:0] ST_GC_DATA_NACK  = 8'h98;
    localparam logic [7:0] ST_STOP          = 8'hA0;

    typedef enum logic [2:0] {
        S_IDLE,
        S_ADDR,
        S_AACK,
        S_DATA,
        S_DACK,
        S_HOLD,
        S_GEN
    } tws_state_e;

endpackage

// >>> src/tws_slave_rx.sv
// two-wire slave receiver with status codes and step flag handshake
// assumes open-drain pads outside; register port on the same clock
//
// Summary of operation
// - general-call byte acked: report 0x90; next byte acked per ack_enable.
// - general-call byte nacked: report 0x98; after clear go not addressed.
// - stop or restart while addressed: report 0xA0, then go not addressed.
// - after clear with ack_enable zero: ignore own and general-call address.
// - ack_enable one: own address recognised, general call only if enabled.
// - start_request one at clear: queue start, send it once bus is free.
// - own address write: 0x60, then 0x80 per byte, then 0xA0.
// - last own-address byte nacked: report 0x88 instead of 0x80.
// - addressed after lost arbitration: 0x68 own, 0x78 general call.
// - general call: 0x70, then 0x90 or 0x98 per byte, then 0xA0.
// - ack_enable cleared mid-transfer: nack next byte; own address not acked.
// - own address register: bit 0 general-call enable, bits 7:1 address.
// - step flag cleared by writing one; bus clock held low while set.
//
// Added by the designer: the address map and strobed register access.
`timescale 1ns/100ps
`default_nettype none
module tws_slave_rx #(
    parameter int HOLD_CYC = tws_pkg::START_HOLD_CYC
) (
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     reset_n,
    // register port
    input  wire logic [tws_pkg::REG_AW-1:0] reg_addr,
    input  wire logic [tws_pkg::REG_DW-1:0] reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic      [tws_pkg::REG_DW-1:0] reg_rdata,
    // bus pins, open drain
    input  wire logic                     scl_i,
    input  wire logic                     sda_i,
    output logic                          scl_o,
    output logic                          scl_oe,
    output logic                          sda_o,
    output logic                          sda_oe,
    // interrupt
    output logic                          irq
);

    localparam int HW = $clog2(HOLD_CYC + 1);

    if (HOLD_CYC < 1) begin : g_bad_hold
        $error("HOLD_CYC must be at least one");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // reset release

    logic rst_n_q1;
    logic rst_n;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_n_q1 <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_n_q1 <= 1'b1;
            rst_n    <= rst_n_q1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and condition detector

    logic [1:0] pins_s;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_det;
    logic       stop_det;

    tws_sync #(
        .W    (2)
    ) u_sync (
        .clk  (clk),
        .rst_n(rst_n),
        .din  ({scl_i, sda_i}),
        .dout (pins_s)
    );

    tws_cond u_cond (
        .clk      (clk),
        .rst_n    (rst_n),
        .scl      (pins_s[1]),
        .sda      (pins_s[0]),
        .scl_rise (scl_rise),
        .scl_fall (scl_fall),
        .start_det(start_det),
        .stop_det (stop_det)
    );

    wire sda_s = pins_s[0];

    ////////////////////////////////////////////////////////////////////////////////
    // state

    tws_pkg::tws_state_e state_q;
    tws_pkg::tws_state_e state_d;

    logic [3:0]                 cnt_q;
    logic [3:0]                 cnt_d;
    logic [7:0]                 shift_q;
    logic [7:0]                 shift_d;
    logic                       gc_q;
    logic                       gc_d;
    logic                       arb_q;
    logic                       arb_d;
    logic                       end_q;
    logic                       end_d;
    logic                       sda_oe_q;
    logic                       sda_d;
    logic [HW-1:0]              hold_q;
    logic [HW-1:0]              hold_d;
    logic                       busy_q;
    logic                       start_pend_q;
    logic                       step_q;
    logic [7:0]                 status_q;
    logic [7:0]                 code_d;
    logic                       set_step;
    logic                       load_data;
    logic                       stop_evt;
    logic                       gen_done;

    // software visible
    logic                       ack_en_q;
    logic                       sta_q;
    logic                       sto_q;
    logic                       en_q;
    logic [tws_pkg::PRESC_W-1:0] presc_q;
    logic [7:0]                 data_q;
    logic [7:0]                 own_addr_q;
    logic [tws_pkg::IRQ_W-1:0]  irq_stat_q;
    logic [tws_pkg::IRQ_W-1:0]  irq_mask_q;
    logic                       irq_q;
    logic [7:0]                 rdata_q;

    ////////////////////////////////////////////////////////////////////////////////
    // decode

    function automatic logic hit(input logic [2:0] a, input logic [2:0] r);
        return a == r;
    endfunction

    wire wr_ctrl  = reg_wr && hit(reg_addr, tws_pkg::REG_CTRL);
    wire wr_stat  = reg_wr && hit(reg_addr, tws_pkg::REG_STATUS);
    wire wr_data  = reg_wr && hit(reg_addr, tws_pkg::REG_DATA);
    wire wr_own   = reg_wr && hit(reg_addr, tws_pkg::REG_OWN_ADDR);
    wire wr_istat = reg_wr && hit(reg_addr, tws_pkg::REG_IRQ_STAT);
    wire wr_imask = reg_wr && hit(reg_addr, tws_pkg::REG_IRQ_MASK);

    // a written one clears the flag and goes on
    wire step_clr = wr_ctrl && reg_wdata[tws_pkg::CTRL_STEP];

    // ack_enable zero blocks both own and general-call address matches
    wire hit_own  = ack_en_q && !shift_q[0]
                 && shift_q[7:1] == own_addr_q[7:1];
    wire hit_gc   = ack_en_q && !shift_q[0] && own_addr_q[tws_pkg::OWN_GCE]
                 && shift_q[7:1] == tws_pkg::GC_ADDR;
    wire byte_done = cnt_q == tws_pkg::BITS_PER_BYTE;
    wire hold_end  = hold_q == HW'(HOLD_CYC - 1);
    wire bus_cond  = start_det || stop_det;

    wire [7:0] code_addr = gc_d ? (arb_d ? tws_pkg::ST_ARB_GC : tws_pkg::ST_GC_ACK)
                                : (arb_d ? tws_pkg::ST_ARB_OWN : tws_pkg::ST_OWN_ACK);
    wire [7:0] code_gc   = sda_oe_q ? tws_pkg::ST_GC_DATA_ACK : tws_pkg::ST_GC_DATA_NACK;
    wire [7:0] code_own  = sda_oe_q ? tws_pkg::ST_OWN_DATA_ACK : tws_pkg::ST_OWN_DATA_NACK;

    ////////////////////////////////////////////////////////////////////////////////
    // bus state machine

    always_comb begin
        state_d   = state_q;
        cnt_d     = cnt_q;
        shift_d   = shift_q;
        gc_d      = gc_q;
        arb_d     = arb_q;
        end_d     = end_q;
        sda_d     = sda_oe_q;
        hold_d    = hold_q;
        code_d    = status_q;
        set_step  = 1'b0;
        load_data = 1'b0;
        stop_evt  = 1'b0;
        gen_done  = 1'b0;
        case (state_q)
            tws_pkg::S_IDLE: begin
                sda_d = 1'b0;
                if (start_det) begin
                    state_d = tws_pkg::S_ADDR;
                    cnt_d   = '0;
                end else if (start_pend_q && !busy_q) begin
                    state_d = tws_pkg::S_GEN;
                    hold_d  = '0;
                end
            end
            tws_pkg::S_ADDR: begin
                if (stop_det) begin
                    state_d = tws_pkg::S_IDLE;
                end else if (start_det) begin
                    cnt_d = '0;
                end else if (scl_rise && !byte_done) begin
                    shift_d = {shift_q[6:0], sda_s};
                    cnt_d   = cnt_q + 4'h1;
                end else if (scl_fall && byte_done) begin
                    if (hit_own || hit_gc) begin
                        state_d = tws_pkg::S_AACK;
                        sda_d   = 1'b1;
                        gc_d    = hit_gc && !hit_own;
                        // a queued start that never got the bus lost arbitration
                        arb_d   = start_pend_q;
                    end else begin
                        state_d = tws_pkg::S_IDLE;
                    end
                end
            end
            tws_pkg::S_AACK: begin
                if (scl_fall) begin
                    sda_d    = 1'b0;
                    state_d  = tws_pkg::S_HOLD;
                    end_d    = 1'b0;
                    set_step = 1'b1;
                    code_d   = code_addr;
                end
            end
            tws_pkg::S_DATA: begin
                if (bus_cond) begin
                    state_d  = tws_pkg::S_HOLD;
                    end_d    = 1'b1;
                    set_step = 1'b1;
                    stop_evt = 1'b1;
                    code_d   = tws_pkg::ST_STOP;
                end else if (scl_rise && !byte_done) begin
                    shift_d = {shift_q[6:0], sda_s};
                    cnt_d   = cnt_q + 4'h1;
                end else if (scl_fall && byte_done) begin
                    state_d = tws_pkg::S_DACK;
                    // live bit: clearing it mid-transfer nacks the next byte
                    sda_d   = ack_en_q;
                end
            end
            tws_pkg::S_DACK: begin
                if (scl_fall) begin
                    sda_d     = 1'b0;
                    state_d   = tws_pkg::S_HOLD;
                    load_data = 1'b1;
                    set_step  = 1'b1;
                    end_d     = !sda_oe_q;
                    code_d    = gc_q ? code_gc : code_own;
                end
            end
            tws_pkg::S_HOLD: begin
                if (!step_q) begin
                    cnt_d = '0;
                    if (end_q) begin
                        state_d = tws_pkg::S_IDLE;
                    end else begin
                        state_d = tws_pkg::S_DATA;
                    end
                end
            end
            tws_pkg::S_GEN: begin
                // sda low with scl high; release later reads as a stop
                sda_d  = 1'b1;
                hold_d = hold_q + HW'(1);
                if (hold_end) begin
                    sda_d    = 1'b0;
                    state_d  = tws_pkg::S_HOLD;
                    end_d    = 1'b1;
                    gen_done = 1'b1;
                    set_step = 1'b1;
                    code_d   = tws_pkg::ST_START_SENT;
                end
            end
            default: begin
                state_d = tws_pkg::S_IDLE;
                sda_d   = 1'b0;
            end
        endcase
        if (!en_q) begin
            state_d = tws_pkg::S_IDLE;
            sda_d   = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q  <= tws_pkg::S_IDLE;
            cnt_q    <= '0;
            shift_q  <= '0;
            gc_q     <= 1'b0;
            arb_q    <= 1'b0;
            end_q    <= 1'b0;
            sda_oe_q <= 1'b0;
            hold_q   <= '0;
        end else begin
            state_q  <= state_d;
            cnt_q    <= cnt_d;
            shift_q  <= shift_d;
            gc_q     <= gc_d;
            arb_q    <= arb_d;
            end_q    <= end_d;
            sda_oe_q <= sda_d;
            hold_q   <= hold_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // step flag, status and bus tracking

    // set beats a same-cycle clear so no event is lost
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            step_q   <= 1'b0;
            status_q <= tws_pkg::ST_NONE;
        end else begin
            step_q   <= set_step || (step_q && !step_clr);
            status_q <= code_d;
        end
    end

    // queued by the clearing write
    wire pend_set = step_clr && step_q && end_q && reg_wdata[tws_pkg::CTRL_STA];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_q       <= 1'b0;
            start_pend_q <= 1'b0;
        end else begin
            busy_q       <= start_det || (busy_q && !stop_det);
            start_pend_q <= en_q && (pend_set || (start_pend_q && !gen_done));
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // software registers

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_en_q <= 1'b0;
            sta_q    <= 1'b0;
            sto_q    <= 1'b0;
            en_q     <= 1'b0;
        end else if (wr_ctrl) begin
            ack_en_q <= reg_wdata[tws_pkg::CTRL_ACK];
            sta_q    <= reg_wdata[tws_pkg::CTRL_STA];
            // stored only, never acted on
            sto_q    <= reg_wdata[tws_pkg::CTRL_STO];
            en_q     <= reg_wdata[tws_pkg::CTRL_EN];
        end
    end

    // received byte lands on the same clock edge as the flag rises
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data_q <= tws_pkg::DATA_RST;
        end else if (load_data) begin
            data_q <= shift_q;
        end else if (wr_data) begin
            data_q <= reg_wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            own_addr_q <= tws_pkg::OWN_ADDR_RST;
            presc_q    <= '0;
            irq_mask_q <= '0;
        end else begin
            if (wr_own) begin
                own_addr_q <= reg_wdata;
            end
            if (wr_stat) begin
                presc_q <= reg_wdata[tws_pkg::PRESC_W-1:0];
            end
            if (wr_imask) begin
                irq_mask_q <= reg_wdata[tws_pkg::IRQ_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // interrupts

    wire [tws_pkg::IRQ_W-1:0] irq_evt = {gen_done, stop_evt, set_step};
    wire [tws_pkg::IRQ_W-1:0] irq_clr = wr_istat ? reg_wdata[tws_pkg::IRQ_W-1:0] : '0;
    wire [tws_pkg::IRQ_W-1:0] irq_nxt = irq_evt | (irq_stat_q & ~irq_clr);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_q <= '0;
            irq_q      <= 1'b0;
        end else begin
            irq_stat_q <= irq_nxt;
            irq_q      <= |(irq_nxt & irq_mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read port

    // software masks the low prescaler bits off
    wire [7:0] rd_status = {status_q[7:3], 1'b0, presc_q};
    wire [7:0] rd_ctrl   = {step_q, ack_en_q, sta_q, sto_q, 1'b0, en_q, 2'b00};
    wire [7:0] rd_val    =
        hit(reg_addr, tws_pkg::REG_CTRL)     ? rd_ctrl :
        hit(reg_addr, tws_pkg::REG_STATUS)   ? rd_status :
        hit(reg_addr, tws_pkg::REG_DATA)     ? data_q :
        hit(reg_addr, tws_pkg::REG_OWN_ADDR) ? own_addr_q :
        hit(reg_addr, tws_pkg::REG_IRQ_STAT) ? {5'h00, irq_stat_q} :
        hit(reg_addr, tws_pkg::REG_IRQ_MASK) ? {5'h00, irq_mask_q} :
        8'h00;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= reg_rd ? rd_val : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    // pads only ever pull low
    logic low_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            low_q <= 1'b0;
        end else begin
            low_q <= 1'b0;
        end
    end

    assign reg_rdata = rdata_q;
    assign sda_oe    = sda_oe_q;
    assign sda_o     = low_q;
    // clock stretched while the flag stands
    assign scl_oe    = step_q;
    assign scl_o     = low_q;
    assign irq       = irq_q;

endmodule
`default_nettype wire

// >>> src/tws_sync.sv
// two-flop synchroniser for pin inputs
// assumes inputs are asynchronous to clk
`timescale 1ns/100ps
`default_nettype none
module tws_sync #(
    parameter int W = 2
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // async in, synced out
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    logic [W-1:0] meta_q;

    if (W < 1) begin : g_bad_width
        $error("tws_sync width must be at least one");
    end

    // pins idle high, so reset to ones
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '1;
            dout   <= '1;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end

endmodule
`default_nettype wire

// >>> testbench/tb_two_wire_slave_receiver_states.sv
// self-checking bench for the slave receiver
// assumes package, design and master compiled first
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_two_wire_slave_receiver_states;
    localparam logic [6:0] ME = 7'h5A;
    localparam logic [7:0] RST_V [5] = '{8'h00, tws_pkg::ST_NONE, tws_pkg::DATA_RST, tws_pkg::OWN_ADDR_RST, 8'h00};
    logic       clk = 1'b0;
    logic       reset_n = 1'b0;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [7:0] reg_rdata, r;
    logic       scl_o, scl_oe, sda_o, sda_oe, irq, scl_dn, sda_dn, scl_w, sda_w, nk;
    int         n_mismatch;
    int         n_compared;
    int         seed = 84230;
    logic [7:0] data_q[$];
    always #2.5 clk = ~clk;
    assign scl_w = !((scl_oe && !scl_o) || scl_dn);
    assign sda_w = !((sda_oe && !sda_o) || sda_dn);
    tws_slave_rx #(.HOLD_CYC(8)) i_dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_i(scl_w), .sda_i(sda_w), .scl_o(scl_o),
        .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));
    tws_bus_master i_mst (.scl(scl_w), .sda(sda_w), .scl_dn(scl_dn), .sda_dn(sda_dn));
    ////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        n_mismatch += i_mst.n_stuck;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic xfer(input logic [7:0] b, input logic exp_nack, input logic is_data);
        if (is_data) data_q.push_back(b);
        i_mst.send(b, nk);
        `CHK(nk, exp_nack)
    endtask
    // await step, check it, answer with ctl
    task automatic step(input logic [7:0] st, input logic [7:0] ctl);
        int k;
        logic [7:0] v;
        for (k = 0; k < 4000 && irq !== 1'b1; k++) @(posedge clk);
        if (k == 4000) begin
            n_mismatch++;
            tally_and_finish();
        end
        wr(tws_pkg::REG_STATUS, 8'($random(seed)) & 8'h03);
        rd(tws_pkg::REG_STATUS, v);
        `CHK(v & 8'hF8, st)
        rd(tws_pkg::REG_IRQ_STAT, v);
        `CHK(v[2:0], {st == 8'h08, st == 8'hA0, 1'b1})
        if (st inside {8'h80, 8'h88, 8'h90, 8'h98}) begin
            rd(tws_pkg::REG_DATA, v);
            `CHK(v, data_q.pop_front())
        end
        wr(tws_pkg::REG_IRQ_STAT, 8'h07);
        wr(tws_pkg::REG_CTRL, ctl);
        `CHK(irq, 1'b0)
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 5; i++) begin
            rd(3'(i == 4 ? 6 : i), r);
            `CHK(r, RST_V[i])
        end
        wr(tws_pkg::REG_IRQ_MASK, 8'h00);
        wr(tws_pkg::REG_IRQ_MASK, 8'h01);
        wr(tws_pkg::REG_OWN_ADDR, {ME, 1'b1});
        wr(tws_pkg::REG_CTRL, 8'h44);
        i_mst.cond(1'b1);
        xfer({ME, 1'b0}, 1'b0, 1'b0);
        step(8'h60, 8'hC4);
        xfer(8'($random(seed)), 1'b0, 1'b1);
        step(8'h80, 8'hC4);
        xfer(8'($random(seed)), 1'b0, 1'b1);
        step(8'h80, 8'h84);
        xfer(8'($random(seed)), 1'b1, 1'b1);
        step(8'h88, 8'h84);
        i_mst.cond(1'b0);
        i_mst.cond(1'b1);
        xfer({ME, 1'b0}, 1'b1, 1'b0);
        i_mst.cond(1'b0);
        $display("own address test done");
        wr(tws_pkg::REG_CTRL, 8'h44);
        i_mst.cond(1'b1);
        xfer(8'h00, 1'b0, 1'b0);
        step(8'h70, 8'hC4);
        xfer(8'($random(seed)), 1'b0, 1'b1);
        step(8'h90, 8'h84);
        xfer(8'($random(seed)), 1'b1, 1'b1);
        step(8'h98, 8'hC4);
        wr(tws_pkg::REG_OWN_ADDR, {ME, 1'b0});
        i_mst.cond(1'b1);
        xfer(8'h00, 1'b1, 1'b0);
        i_mst.cond(1'b1);
        xfer({ME, 1'b0}, 1'b0, 1'b0);
        step(8'h60, 8'hC4);
        i_mst.cond(1'b1);
        step(8'hA0, 8'hE4);
        i_mst.cond(1'b1);
        xfer({ME, 1'b0}, 1'b0, 1'b0);
        step(8'h68, 8'hC4);
        i_mst.cond(1'b0);
        step(8'hA0, 8'hC4);
        step(8'h08, 8'h44);
        $display("general call test done");
        tally_and_finish();
    end
endmodule
`default_nettype wire

// >>> testbench/tws_bus_master.sv
// behavioural two-wire bus master, 48 ns bit time
// assumes pull-ups: lines idle high
`timescale 1ns/100ps
`default_nettype none
module tws_bus_master (
    input  wire logic scl,
    input  wire logic sda,
    output logic      scl_dn,
    output logic      sda_dn
);
    int n_stuck;
    initial begin
        scl_dn = 1'b0;
        sda_dn = 1'b0;
    end
    // bounded wait; the slave may stretch scl
    task automatic rise();
        scl_dn = 1'b0;
        for (int k = 0; k < 4000 && scl !== 1'b1; k++) #5;
        if (scl !== 1'b1) n_stuck++;
    endtask
    // start or restart if st, else stop
    task automatic cond(input logic st);
        #12;
        sda_dn = !st;
        #12;
        rise();
        #24;
        sda_dn = st;
        #24;
        scl_dn = st;
    endtask
    // msb first; sda moves only while scl is low
    task automatic send(input logic [7:0] b, output logic nack);
        for (int i = 8; i >= 0; i--) begin
            #12;
            sda_dn = (i > 0) ? !b[i-1] : 1'b0;
            #12;
            rise();
            #24;
            nack = sda;
            scl_dn = 1'b1;
        end
    endtask
endmodule
`default_nettype wire

// >>> testbench/tws_slave_rx_sva.sv
// port-level checker of the slave receiver
// assumes a bind into tws_slave_rx; sees ports only
`timescale 1ns/100ps
`default_nettype none
module tws_slave_rx_chk (
    input wire logic       clk,
    input wire logic       reset_n,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       scl_oe,
    input wire logic       sda_oe,
    input wire logic       irq
);
    logic noack_q;
    wire  ctl_wr = reg_wr && reg_addr == tws_pkg::REG_CTRL;
    // no sda pull while ack and start are off
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) noack_q <= 1'b1;
        else if (ctl_wr) noack_q <= !reg_wdata[6] && !reg_wdata[5];
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////
    chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not idle");
    chk_unmapped_zero: assert property (reg_rd && reg_addr > 3'h5 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_status_valid: assert property (reg_rd && reg_addr == tws_pkg::REG_STATUS && scl_oe
        |=> reg_rdata[7:3] != 5'h1F && !reg_rdata[2]) else $error("status stale at step");
    chk_step_hold: assert property (scl_oe && !(ctl_wr && reg_wdata[7]) |=> scl_oe)
        else $error("step dropped without clear");
    chk_step_clear: assert property (scl_oe && ctl_wr && reg_wdata[7] |=> !scl_oe)
        else $error("step not cleared");
    chk_noack_quiet: assert property (noack_q |-> !sda_oe)
        else $error("ack driven while disabled");
    chk_mask_off: assert property (reg_wr && reg_addr == tws_pkg::REG_IRQ_MASK && reg_wdata == 8'h00
        |-> ##2 !irq) else $error("irq with all masked");
    chk_reset_quiet: assert property ($rose(reset_n) |-> (!scl_oe && !sda_oe && !irq) [*2])
        else $error("outputs active after reset");
    cover property ($rose(scl_oe));
    cover property ($rose(sda_oe));
    cover property ($rose(irq));
endmodule
bind tws_slave_rx tws_slave_rx_chk i_chk (
    .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_oe(scl_oe), .sda_oe(sda_oe), .irq(irq));
`default_nettype wire
